// >>> common/brwc_pkg.sv
// Purpose: Constants, register map and types of the bridge ratio weight core.
// Assumes: 10 MHz pclk, APB word registers at byte address four times the index.
// Notes: Shared by the core, its assertions and the bench.
package brwc_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0] IDX_STATUS = 8'h00;
    localparam logic [7:0] IDX_RESULT = 8'h01;
    localparam logic [7:0] IDX_DIFF = 8'h02;
    localparam logic [7:0] IDX_REF = 8'h03;
    localparam logic [7:0] IDX_RSTAT = 8'h04;
    localparam logic [7:0] IDX_MK_OFS = 8'h13;
    localparam logic [7:0] IDX_MK_GAIN = 8'h14;
    localparam logic [7:0] IDX_FEATURE = 8'h20;
    localparam logic [7:0] IDX_US_OFS = 8'h21;
    localparam logic [7:0] IDX_US_GAIN = 8'h22;
    localparam logic [7:0] IDX_NOM_W = 8'h23;
    localparam logic [7:0] IDX_NOM_S = 8'h24;
    localparam logic [7:0] IDX_FILT = 8'h25;
    localparam logic [7:0] IDX_SCALE = 8'h26;
    localparam logic [7:0] IDX_REF_IVL = 8'h27;
    localparam int ADDR_W = 12;
    // Feature and status bit positions
    localparam int FB_USER_EN = 0;
    localparam int FB_MAKER_EN = 1;
    localparam int FB_SCALE_EN = 8;
    localparam int FB_USER_MODE = 10;
    localparam int SB_DIFF_SIGN = 0;
    localparam int SB_REF_SIGN = 1;
    localparam int SB_BUSY = 4;
    localparam int SB_RESULT_SIGN = 0;
    localparam logic [15:0] FEATURE_MASK = 16'h0503;
    // Reset values
    localparam logic [15:0] RST_GAIN = 16'h0100;
    localparam logic [15:0] RST_OFS = 16'h0000;
    localparam logic [15:0] RST_NOM = 16'h0001;
    localparam logic [15:0] RST_FILT = 16'h0001;
    localparam logic [15:0] RST_REF_IVL = 16'h000A;
    localparam logic [15:0] RST_FEATURE = 16'h0000;
    // Arithmetic
    localparam int GAIN_FRAC = 8;
    localparam logic [15:0] MAG_MAX = 16'hFFFF;
    localparam int MAG_W = 16;
    localparam int RES_W = MAG_W + 1;
    localparam int DIV_W = 33;
    localparam int FIFO_DEPTH = 8;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int REF_BASE_MS = 100;
    localparam int REF_BASE_CYCLES = REF_BASE_MS * (CLK_HZ / 1000);
    localparam int DIFF_STEP_US = 1000;
    localparam int DIFF_STEP_CYCLES = DIFF_STEP_US * (CLK_HZ / 1_000_000);
    // Sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CONV = 7'h02,
        ST_DIV = 7'h04,
        ST_SCALE = 7'h08,
        ST_MAKER = 7'h10,
        ST_USER = 7'h20,
        ST_PUSH = 7'h40
    } brwc_state_t;
endpackage

// >>> design/brwc_core.sv
// Purpose: Acquisition sequencer, ratio weight arithmetic, APB registers and result FIFO.
// Assumes: Converter answers each start with one conv_done pulse; inputs synchronous to pclk.
// Notes: The converter is shared, so only one conversion is ever in flight.
`timescale 1ns/1ns

module brwc_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [W-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [W-1:0] m_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    logic [PW:0] cnt_reg;
    wire push = s_valid && s_ready;
    wire pop = m_valid && m_ready;

    // Honest flags straight from the occupancy count
    assign s_ready = (cnt_reg != (PW+1)'(DEPTH));
    assign m_valid = (cnt_reg != '0);
    assign m_data = mem[rd_reg];

    // Storage has no reset; only the pointers and the count carry control state
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_reg] <= s_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // brwc_fifo

module brwc_core #(
    parameter int REF_TICK_CYCLES = brwc_pkg::REF_BASE_CYCLES,
    parameter int DIFF_TICK_CYCLES = brwc_pkg::DIFF_STEP_CYCLES,
    parameter int DEPTH = brwc_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brwc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic conv_start,
    output logic conv_ref_sel,
    input wire logic conv_done,
    input wire logic conv_sign,
    input wire logic [brwc_pkg::MAG_W-1:0] conv_mag,
    output logic out_valid,
    input wire logic out_ready,
    output logic [brwc_pkg::RES_W-1:0] out_data
);
    import brwc_pkg::*;

    // Software registers
    logic [15:0] mk_ofs_reg, mk_gain_reg, us_ofs_reg, us_gain_reg;
    logic [15:0] nom_w_reg, nom_s_reg, filt_reg, scale_reg, ref_ivl_reg, feature_reg;
    // Measurement and result state
    logic [15:0] diff_mag_reg, ref_mag_reg, res_mag_reg;
    logic diff_sign_reg, ref_sign_reg, res_sign_reg;
    brwc_state_t state_reg;
    logic conv_start_reg, conv_ref_sel_reg, last_ref_reg;
    logic diff_pend_reg, ref_pend_reg;
    logic [31:0] diff_cnt_reg, ref_tick_reg;
    logic [15:0] ref_step_reg;
    logic [DIV_W-1:0] div_num_reg;
    logic [DIV_W:0] div_rem_reg;
    logic [5:0] div_cnt_reg;
    logic signed [31:0] acc_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic out_valid_reg;
    logic [RES_W-1:0] out_data_reg;

    // Clamp a wide signed value into 32 bits so later stages cannot wrap
    function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        hi = 64'sh0000_0000_7FFF_FFFF;
        lo = -64'sh0000_0000_8000_0000;
        if (v > hi) begin
            return 32'sh7FFF_FFFF;
        end else if (v < lo) begin
            return 32'sh8000_0000;
        end
        return v[31:0];
    endfunction

    // APB decode
    wire [7:0] idx = paddr[9:2];
    wire addr_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
    wire access = psel && penable;
    wire wr_take = access && pwrite && pready_reg;
    wire hit_ro = (idx == IDX_STATUS) || (idx == IDX_RESULT) || (idx == IDX_DIFF) ||
                  (idx == IDX_REF) || (idx == IDX_RSTAT);
    wire hit_rw = (idx == IDX_MK_OFS) || (idx == IDX_MK_GAIN) || (idx == IDX_FEATURE) ||
                  (idx == IDX_US_OFS) || (idx == IDX_US_GAIN) || (idx == IDX_NOM_W) ||
                  (idx == IDX_NOM_S) || (idx == IDX_FILT) || (idx == IDX_SCALE) || (idx == IDX_REF_IVL);
    wire addr_err = !addr_ok || !(hit_ro || hit_rw) || (pwrite && hit_ro);
    wire busy = (state_reg != ST_IDLE);
    wire [15:0] status_word = 16'(({15'h0000, busy} << SB_BUSY) | ({15'h0000, ref_sign_reg} << SB_REF_SIGN) |
                              ({15'h0000, diff_sign_reg} << SB_DIFF_SIGN));
    wire [15:0] rstat_word = 16'({15'h0000, res_sign_reg} << SB_RESULT_SIGN);
    logic [15:0] rd_mux;
    always_comb begin
        case (idx)
            IDX_STATUS: rd_mux = status_word;
            IDX_RESULT: rd_mux = res_mag_reg;
            IDX_DIFF: rd_mux = diff_mag_reg;
            IDX_REF: rd_mux = ref_mag_reg;
            IDX_RSTAT: rd_mux = rstat_word;
            IDX_MK_OFS: rd_mux = mk_ofs_reg;
            IDX_MK_GAIN: rd_mux = mk_gain_reg;
            IDX_FEATURE: rd_mux = feature_reg;
            IDX_US_OFS: rd_mux = us_ofs_reg;
            IDX_US_GAIN: rd_mux = us_gain_reg;
            IDX_NOM_W: rd_mux = nom_w_reg;
            IDX_NOM_S: rd_mux = nom_s_reg;
            IDX_FILT: rd_mux = filt_reg;
            IDX_SCALE: rd_mux = scale_reg;
            IDX_REF_IVL: rd_mux = ref_ivl_reg;
            default: rd_mux = 16'h0000;
        endcase
    end

    // One wait state so that read data and error leave from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && addr_err;
            prdata_reg <= (access && !pready_reg && !pwrite && !addr_err) ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    // Configuration writes land at the edge where pready is sampled high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mk_ofs_reg <= RST_OFS;
            mk_gain_reg <= RST_GAIN;
            us_ofs_reg <= RST_OFS;
            us_gain_reg <= RST_GAIN;
            nom_w_reg <= RST_NOM;
            nom_s_reg <= RST_NOM;
            filt_reg <= RST_FILT;
            scale_reg <= RST_GAIN;
            ref_ivl_reg <= RST_REF_IVL;
            feature_reg <= RST_FEATURE;
        end else if (wr_take && !addr_err) begin
            case (idx)
                IDX_MK_OFS: mk_ofs_reg <= pwdata[15:0];
                IDX_MK_GAIN: mk_gain_reg <= pwdata[15:0];
                IDX_FEATURE: feature_reg <= pwdata[15:0] & FEATURE_MASK;
                IDX_US_OFS: us_ofs_reg <= pwdata[15:0];
                IDX_US_GAIN: us_gain_reg <= pwdata[15:0];
                IDX_NOM_W: nom_w_reg <= pwdata[15:0];
                IDX_NOM_S: nom_s_reg <= pwdata[15:0];
                IDX_FILT: filt_reg <= pwdata[15:0];
                IDX_SCALE: scale_reg <= pwdata[15:0];
                IDX_REF_IVL: ref_ivl_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Sampling timers; a zero setting is taken as one step to avoid a stuck timer
    wire [15:0] filt_steps = (filt_reg == 16'h0000) ? 16'h0001 : filt_reg;
    wire [31:0] diff_reload = 32'(filt_steps * DIFF_TICK_CYCLES) - 32'd1;
    wire [15:0] ref_steps = (ref_ivl_reg == 16'h0000) ? 16'h0001 : ref_ivl_reg;
    wire diff_exp = (diff_cnt_reg == 32'h0000_0000);
    wire ref_tick = (ref_tick_reg == 32'h0000_0000);
    wire ref_exp = ref_tick && (ref_step_reg <= 16'h0001);
    // Alternate when both are due so neither starves the other
    wire pick_ref = ref_pend_reg && (!diff_pend_reg || !last_ref_reg);
    wire start = (state_reg == ST_IDLE) && (diff_pend_reg || ref_pend_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diff_cnt_reg <= 32'h0000_0000;
            ref_tick_reg <= 32'h0000_0000;
            ref_step_reg <= 16'h0000;
            diff_pend_reg <= 1'b0;
            ref_pend_reg <= 1'b0;
        end else begin
            diff_cnt_reg <= diff_exp ? diff_reload : diff_cnt_reg - 32'd1;
            ref_tick_reg <= ref_tick ? 32'(REF_TICK_CYCLES - 1) : ref_tick_reg - 32'd1;
            if (ref_tick) begin
                ref_step_reg <= ref_exp ? ref_steps : ref_step_reg - 16'h0001;
            end
            // A new expiry wins over the clear of a taken request
            diff_pend_reg <= diff_exp || (diff_pend_reg && !(start && !pick_ref));
            ref_pend_reg <= ref_exp || (ref_pend_reg && !(start && pick_ref));
        end
    end

    // Divider: numerator diff*nomw*2, denominator ref*noms, covers *1000/500 exactly
    // Operands widened first: inside a concatenation the product would keep only 16 bits
    wire [DIV_W-1:0] num_init = {(DIV_W-1)'(diff_mag_reg) * (DIV_W-1)'(nom_w_reg), 1'b0};
    wire [31:0] den = ref_mag_reg * nom_s_reg;
    wire [DIV_W:0] trial = {div_rem_reg[DIV_W-1:0], div_num_reg[DIV_W-1]};
    wire ge = (trial >= {2'b00, den});
    wire [DIV_W:0] rem_sub = trial - {2'b00, den};
    // A zero denominator yields an all-ones quotient, which then saturates
    wire res_neg = diff_sign_reg ^ ref_sign_reg;
    wire signed [63:0] q_signed = res_neg ? -$signed({31'h0, div_num_reg}) : $signed({31'h0, div_num_reg});

    // Scaling stages on a 32-bit saturating accumulator
    wire signed [63:0] acc_w = 64'(acc_reg);
    wire signed [63:0] sc_prod = (acc_w * $signed({48'h0, scale_reg})) >>> GAIN_FRAC;
    wire signed [63:0] mk_res = ((acc_w * $signed({48'h0, mk_gain_reg})) >>> GAIN_FRAC) +
                                64'($signed(mk_ofs_reg));
    wire signed [63:0] us_res0 = ((acc_w * $signed({48'h0, us_gain_reg})) >>> GAIN_FRAC) +
                                 64'($signed(us_ofs_reg));
    wire signed [63:0] us_res1 = ((acc_w + 64'($signed(us_ofs_reg))) * $signed({48'h0, us_gain_reg})) >>> GAIN_FRAC;
    wire [31:0] acc_abs = acc_reg[31] ? 32'(-acc_reg) : 32'(acc_reg);
    wire [15:0] fin_mag = (acc_abs > {16'h0000, MAG_MAX}) ? MAG_MAX : acc_abs[15:0];
    wire fin_sign = acc_reg[31];

    // FIFO handshake towards the result stream
    logic fifo_s_ready, fifo_m_valid;
    logic [RES_W-1:0] fifo_m_data;
    wire fifo_push = (state_reg == ST_PUSH);
    wire fifo_pop = fifo_m_valid && (!out_valid_reg || out_ready);

    brwc_fifo #(
        .W(RES_W),
        .DEPTH(DEPTH)
    ) brwc_fifo_inst (
        .pclk(pclk),
        .presetn(presetn),
        .s_valid(fifo_push),
        .s_ready(fifo_s_ready),
        .s_data({fin_sign, fin_mag}),
        .m_valid(fifo_m_valid),
        .m_ready(fifo_pop),
        .m_data(fifo_m_data)
    );

    // Acquisition and compute sequencer; stalls in push while the FIFO is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            conv_start_reg <= 1'b0;
            conv_ref_sel_reg <= 1'b0;
            last_ref_reg <= 1'b0;
            diff_mag_reg <= 16'h0000;
            diff_sign_reg <= 1'b0;
            ref_mag_reg <= 16'h0000;
            ref_sign_reg <= 1'b0;
            res_mag_reg <= 16'h0000;
            res_sign_reg <= 1'b0;
            div_num_reg <= '0;
            div_rem_reg <= '0;
            div_cnt_reg <= 6'h00;
            acc_reg <= 32'sh0000_0000;
        end else begin
            conv_start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        conv_start_reg <= 1'b1;
                        conv_ref_sel_reg <= pick_ref;
                        last_ref_reg <= pick_ref;
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        if (conv_ref_sel_reg) begin
                            ref_mag_reg <= conv_mag;
                            ref_sign_reg <= conv_sign;
                        end else begin
                            diff_mag_reg <= conv_mag;
                            diff_sign_reg <= conv_sign;
                        end
                        state_reg <= ST_DIV;
                        div_cnt_reg <= 6'h00;
                        div_rem_reg <= '0;
                    end
                end
                ST_DIV: begin
                    if (div_cnt_reg == 6'h00) begin
                        div_num_reg <= num_init;
                        div_cnt_reg <= 6'h01;
                    end else if (div_cnt_reg <= 6'(DIV_W)) begin
                        div_rem_reg <= ge ? rem_sub : trial;
                        div_num_reg <= {div_num_reg[DIV_W-2:0], ge};
                        div_cnt_reg <= div_cnt_reg + 6'h01;
                    end else begin
                        acc_reg <= sat32(q_signed);
                        state_reg <= ST_SCALE;
                    end
                end
                ST_SCALE: begin
                    if (feature_reg[FB_SCALE_EN]) begin
                        acc_reg <= sat32(sc_prod);
                    end
                    state_reg <= ST_MAKER;
                end
                ST_MAKER: begin
                    if (feature_reg[FB_MAKER_EN]) begin
                        acc_reg <= sat32(mk_res);
                    end
                    state_reg <= ST_USER;
                end
                ST_USER: begin
                    if (feature_reg[FB_USER_EN]) begin
                        acc_reg <= sat32(feature_reg[FB_USER_MODE] ? us_res1 : us_res0);
                    end
                    state_reg <= ST_PUSH;
                end
                ST_PUSH: begin
                    if (fifo_s_ready) begin
                        res_mag_reg <= fin_mag;
                        res_sign_reg <= fin_sign;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Output stage keeps the stream ports on flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (fifo_pop) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= fifo_m_data;
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign conv_start = conv_start_reg;
    assign conv_ref_sel = conv_ref_sel_reg;
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
endmodule // brwc_core

// >>> tb/brwc_core_props.sv
// Purpose: Port-level assertions for the bridge ratio weight core.
// Assumes: One pclk domain, presetn active low.
// Notes: Bound to every brwc_core instance.
`timescale 1ns/1ns
module brwc_core_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brwc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_start,
    input wire logic conv_ref_sel,
    input wire logic conv_done,
    input wire logic conv_sign,
    input wire logic [brwc_pkg::MAG_W-1:0] conv_mag,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [brwc_pkg::RES_W-1:0] out_data
);
    import brwc_pkg::*;
    logic busy_q;
    // A conversion is in flight from its start pulse until the converter answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_q <= 1'b0;
        else if (conv_start) busy_q <= 1'b1;
        else if (conv_done) busy_q <= 1'b0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup then first access cycle, and the single wait state answer
    sequence acc_s; psel && !penable ##1 psel && penable; endsequence
    sequence ans_s; !pready ##1 pready; endsequence
    one_conv_a: assert property (conv_start |-> !busy_q) else $error("start while busy");
    sel_hold_a: assert property (busy_q && !conv_done |=> $stable(conv_ref_sel)) else $error("sel moved");
    first_ref_a: assert property ($rose(presetn) |-> ##[1:4] (conv_start && conv_ref_sel)) else $error("no ref");
    calc_gap_a: assert property (conv_done |=> !conv_start [*8]) else $error("start too soon");
    word_due_a: assert property (conv_done |-> ##[1:60] out_valid) else $error("no word");
    ans_time_a: assert property (acc_s |-> ans_s) else $error("bad wait state");
    ans_once_a: assert property (pready |=> !pready) else $error("pready long");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray rdata");
    ro_err_a: assert property (pready && pwrite && paddr[9:2] <= IDX_RSTAT |-> pslverr) else $error("ro write");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("drop");
endmodule // brwc_core_props
bind brwc_core brwc_core_props brwc_core_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_ref_sel(conv_ref_sel), .conv_done(conv_done),
    .conv_sign(conv_sign), .conv_mag(conv_mag), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

// >>> tb/brwc_conv_model.sv
// Purpose: Behavioural shared converter facing the core.
// Assumes: One start at a time; values set by the bench.
// Notes: Prompt on the differential, slow on the reference.
`timescale 1ns/1ns
module brwc_conv_model (
    input wire logic pclk,
    input wire logic conv_start,
    input wire logic conv_ref_sel,
    input wire logic dsgn,
    input wire logic [15:0] dmag,
    input wire logic rsgn,
    input wire logic [15:0] rmag,
    output logic conv_done = 1'b0,
    output logic conv_sign = 1'b0,
    output logic [15:0] conv_mag = 16'h0000
);
    logic [2:0] cnt = 3'h0;
    logic sel = 1'b0;
    // Result lines churn between answers so a stale value is never mistaken for data
    always @(posedge pclk) begin
        conv_done <= 1'b0;
        conv_sign <= ~conv_sign;
        conv_mag <= ~conv_mag;
        if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                conv_done <= 1'b1;
                conv_sign <= sel ? rsgn : dsgn;
                conv_mag <= sel ? rmag : dmag;
            end
        end else if (conv_start) begin
            sel <= conv_ref_sel;
            cnt <= conv_ref_sel ? 3'h6 : 3'h1;
        end
    end
endmodule // brwc_conv_model

// >>> tb/bridge_ratio_weight_calc_test.sv
// Purpose: Self-checking bench for the bridge ratio weight core.
// Assumes: Short tick parameters, APB master in this module.
// Notes: Words are taken only after the pipeline has flushed old settings.
`timescale 1ns/1ns
module bridge_ratio_weight_calc_test;
    import brwc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, out_ready = 1'b1;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, conv_start, conv_ref_sel, conv_done, conv_sign, out_valid, e;
    logic [MAG_W-1:0] conv_mag;
    logic [RES_W-1:0] out_data;
    logic dsgn = 1'b0, rsgn = 1'b0;
    logic [15:0] dmag = 16'h03E8, rmag = 16'h07D0;
    int fail_count = 0, check_count = 0, cyc = 0, nd, nr;
    brwc_core #(.REF_TICK_CYCLES(20), .DIFF_TICK_CYCLES(50), .DEPTH(8)) brwc_core_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_ref_sel(conv_ref_sel),
        .conv_done(conv_done), .conv_sign(conv_sign), .conv_mag(conv_mag), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));
    brwc_conv_model brwc_conv_model_inst (.pclk(pclk), .conv_start(conv_start), .conv_ref_sel(conv_ref_sel),
        .dsgn(dsgn), .dmag(dmag), .rsgn(rsgn), .rmag(rmag), .conv_done(conv_done), .conv_sign(conv_sign),
        .conv_mag(conv_mag));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard: the whole run needs under ten thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            test_done;
        end
    end
    // One APB transfer; request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        check({e, q[30:0]}, exp);
    endtask
    // Skip words that may predate the last setting, then judge one
    task word(input logic [16:0] exp);
        repeat (4) begin
            do @(posedge pclk); while (out_valid !== 1'b1);
        end
        check({15'h0000, out_data}, {15'h0000, exp});
    endtask
    task t_regs;
        logic [7:0] ix [10] = '{IDX_MK_OFS, IDX_MK_GAIN, IDX_FEATURE, IDX_US_OFS, IDX_US_GAIN, IDX_NOM_W,
            IDX_NOM_S, IDX_FILT, IDX_SCALE, IDX_REF_IVL};
        logic [15:0] rv [10] = '{RST_OFS, RST_GAIN, RST_FEATURE, RST_OFS, RST_GAIN, RST_NOM, RST_NOM, RST_FILT,
            RST_GAIN, RST_REF_IVL};
        for (int i = 0; i < 10; i++) rd_chk(ix[i], {16'h0000, rv[i]});
        apb(1'b1, IDX_RESULT, 16'h1234);
        check({31'h0, e}, 32'h1);
        rd_chk(8'h30, 32'h8000_0000);
        apb(1'b1, IDX_FEATURE, 16'hFFFF);
        rd_chk(IDX_FEATURE, {16'h0000, FEATURE_MASK});
        $display("t_regs done");
    endtask
    task t_calc;
        apb(1'b1, IDX_NOM_W, 16'h0064); apb(1'b1, IDX_SCALE, 16'h0200); apb(1'b1, IDX_FEATURE, 16'h0100);
        word(17'h000C8);
        rd_chk(IDX_DIFF, 32'h03E8);
        rd_chk(IDX_REF, 32'h07D0);
        apb(1'b1, IDX_MK_GAIN, 16'h0180); apb(1'b1, IDX_MK_OFS, 16'h0005); apb(1'b1, IDX_FEATURE, 16'h0102);
        word(17'h00131);
        apb(1'b1, IDX_US_GAIN, 16'h0200); apb(1'b1, IDX_US_OFS, 16'hFFF6); apb(1'b1, IDX_FEATURE, 16'h0103);
        word(17'h00258);
        apb(1'b1, IDX_FEATURE, 16'h0503);
        word(17'h0024E);
        dsgn <= 1'b1;
        word(17'h10262);
        rd_chk(IDX_RESULT, 32'h0262);
        rd_chk(IDX_RSTAT, 32'h0001);
        apb(1'b0, IDX_STATUS, 16'h0000);
        check({30'h0, q[SB_REF_SIGN], q[SB_DIFF_SIGN]}, 32'h1);
        $display("t_calc done");
    endtask
    task t_sat;
        apb(1'b1, IDX_FEATURE, 16'h0100); apb(1'b1, IDX_NOM_W, 16'hFFFF);
        word(17'h1FFFF);
        dsgn <= 1'b0;
        word(17'h0FFFF);
        $display("t_sat done");
    endtask
    // Filter 2 gives a 100 cycle differential interval, reference stays 10 x 20 cycles
    task t_rate;
        apb(1'b1, IDX_FILT, 16'h0002);
        nd = 0; nr = 0;
        repeat (2000) begin
            @(posedge pclk);
            if (conv_start === 1'b1 && conv_ref_sel === 1'b1) nr++;
            if (conv_start === 1'b1 && conv_ref_sel === 1'b0) nd++;
        end
        check({31'h0, nd >= 19 && nd <= 21}, 32'h1);
        check({31'h0, nr >= 9 && nr <= 11}, 32'h1);
        apb(1'b1, IDX_FILT, 16'h0001);
        $display("t_rate done");
    endtask
    // Stall the stream until the FIFO refuses, then drain it back to back
    task t_fifo;
        out_ready <= 1'b0;
        repeat (1500) @(posedge pclk);
        nd = 0;
        repeat (300) begin
            @(posedge pclk);
            if (conv_start === 1'b1) nd++;
        end
        check(nd, 0);
        out_ready <= 1'b1;
        repeat (8) begin
            @(posedge pclk);
            check({31'h0, out_valid}, 32'h1);
        end
        $display("t_fifo done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_calc;
        t_sat;
        t_rate;
        t_fifo;
        test_done;
    end
endmodule // bridge_ratio_weight_calc_test
